// ==== core/usart_rx_cfg.svh ====
// constants for the serial receive control block
`ifndef USART_RX_CFG_SVH
`define USART_RX_CFG_SVH
// ============================================================
// bus map
`define RSC_OFF 8'h00
`define RDR_OFF 8'h04
`define MODE_OFF 8'h08
`define ADDR_W 8
// ============================================================
// receive_status_control fields
`define PORT_EN_BIT 7
`define NINE_SEL_BIT 6
`define SINGLE_EN_BIT 5
`define CONT_EN_BIT 4
`define ADDR_DET_BIT 3
`define FRAME_ERR_BIT 2
`define OVERRUN_BIT 1
`define NINTH_BIT 0
`define RSC_RESET 8'h00
// ============================================================
// mode_config fields
`define MODE_SYNC_BIT 0
`define MODE_MASTER_BIT 1
`define MODE_RESET 2'h0
// ============================================================
// buffer entry layout and size
`define ENT_FRAME_ERR 9
`define ENT_BIT8 8
`define BUF_WIDTH 10
`define BUF_DEPTH 2
// ============================================================
// timing
`define CLK_HZ 40000000
`define BAUD_HZ 2500000
`define BIT_CYCLES (`CLK_HZ / `BAUD_HZ)
`define HALF_CYCLES (`BIT_CYCLES / 2)
`define NBITS9 4'h9
`define NBITS8 4'h8
`endif

// ==== core/usart_rx_pkg.sv ====
// types for the serial receive control block
package usart_rx_pkg;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_state_t;
endpackage

// ==== core/rx_buffer.sv ====
// two-entry receive buffer with valid/ready on both sides
`include "usart_rx_cfg.svh"
module rx_buffer #(
  parameter int WIDTH = `BUF_WIDTH,
  parameter int DEPTH = `BUF_DEPTH
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic flush,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW:0] FULL = (AW+1)'(DEPTH);
  localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_q, rd_q;
  logic [AW:0] cnt_q;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;

  function automatic logic [AW-1:0] next_ptr(input logic [AW-1:0] p);
    next_ptr = (p == LAST) ? '0 : AW'(p + 1'b1);
  endfunction

  assign in_ready = (cnt_q != FULL);
  assign out_valid = (cnt_q != '0);
  assign out_data = mem[rd_q];

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_q] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n || flush) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) wr_q <= next_ptr(wr_q);
      if (pop) rd_q <= next_ptr(rd_q);
      cnt_q <= (AW+1)'(cnt_q + push - pop);
    end
  end

  a_no_overfill: assert property (@(posedge clk) disable iff (!rst_n)
    cnt_q == FULL |-> !push) else $error("buffer written while full");
endmodule

// ==== core/usart_receive_control.sv ====
// serial port receive control, status and receiver with AHB-Lite registers
// Notes on behaviour
// RQ1 - port enable drives pins, clear holds reset
// RQ2 - nine-bit select picks 9 or 8 bits
// RQ3 - sync master single receive, self clearing
// RQ4 - continuous enable runs receiver, beats single
// RQ5 - address detect drops async nine-bit bytes with bit8 clear
// RQ6 - framing flag follows head of buffer
// RQ7 - overrun flag cleared only by clearing continuous enable or port enable
// RQ8 - ninth bit shown raw, no parity check
// RQ9 - async, sync master, sync slave modes
// RQ10 - low stop bit stored as framing error
// RQ11 - overrun drops character, blocks reception
`include "usart_rx_cfg.svh"
module usart_receive_control (
  input wire logic CLK,
  input wire logic NRST,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic HREADYOUT,
  output logic [31:0] HRDATA,
  output logic HRESP,
  input wire logic RX_DT,
  input wire logic CK_IN,
  output logic CK_OUT,
  output logic CK_OE,
  output logic SERIAL_PINS_EN,
  output logic RX_DATA_READY
);
  // ============================================================
  // register bus
  logic [7:0] rsc_q;
  logic [1:0] mode_q;
  logic wr_pend_q;
  logic [`ADDR_W-1:0] wr_addr_q;
  logic [31:0] hrdata_q;
  logic hready_q;
  logic hresp_q;
  logic overrun_q;
  logic single_en_q;
  logic ninth_last_q;
  logic rdy_q;

  function automatic logic hit(input logic [`ADDR_W-1:0] a, input logic [`ADDR_W-1:0] off);
    hit = (a == off);
  endfunction

  wire take = HSEL && HTRANS[1] && HREADY;
  wire [`ADDR_W-1:0] a_addr = HADDR[`ADDR_W-1:0];
  wire rd_rsc = take && !HWRITE && hit(a_addr, `RSC_OFF);
  wire rd_rdr = take && !HWRITE && hit(a_addr, `RDR_OFF);
  wire rd_mode = take && !HWRITE && hit(a_addr, `MODE_OFF);
  wire wr_rsc = wr_pend_q && hit(wr_addr_q, `RSC_OFF);
  wire wr_mode = wr_pend_q && hit(wr_addr_q, `MODE_OFF);

  wire port_en = rsc_q[`PORT_EN_BIT];
  wire nine_sel = rsc_q[`NINE_SEL_BIT];
  wire cont_en = rsc_q[`CONT_EN_BIT];
  wire addr_det = rsc_q[`ADDR_DET_BIT];
  wire sync = mode_q[`MODE_SYNC_BIT];
  wire master = mode_q[`MODE_MASTER_BIT];
  wire port_en_nx = wr_rsc ? HWDATA[`PORT_EN_BIT] : port_en;
  wire cont_en_nx = wr_rsc ? HWDATA[`CONT_EN_BIT] : cont_en;

  // ============================================================
  // receive buffer
  logic buf_in_ready, buf_out_valid;
  logic [`BUF_WIDTH-1:0] buf_in_data, buf_out_data;
  logic push, char_done;
  wire pop = rd_rdr && buf_out_valid;

  rx_buffer #(.WIDTH(`BUF_WIDTH), .DEPTH(`BUF_DEPTH)) u_buf (
    .clk(CLK),
    .rst_n(NRST),
    .flush(!port_en),
    .in_valid(push),
    .in_ready(buf_in_ready),
    .in_data(buf_in_data),
    .out_valid(buf_out_valid),
    .out_ready(pop),
    .out_data(buf_out_data)
  );

  // flag and ninth bit follow the oldest unread character
  wire frame_err_view = buf_out_valid && buf_out_data[`ENT_FRAME_ERR]; // RQ6 RQ10
  wire ninth_view = buf_out_valid ? buf_out_data[`ENT_BIT8] : ninth_last_q; // RQ8
  wire [7:0] rsc_view = {rsc_q[7:6], single_en_q, rsc_q[4:3], frame_err_view, overrun_q,
                         ninth_view};
  wire [31:0] rd_val = rd_rsc ? {24'h000000, rsc_view} :
                       rd_rdr ? {24'h000000, buf_out_data[7:0]} :
                       rd_mode ? {30'h0, mode_q} : 32'h00000000;

  always_ff @(posedge CLK) begin
    if (!NRST) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= '0;
      hrdata_q <= 32'h00000000;
      hready_q <= 1'b1;
      hresp_q <= 1'b0;
    end else begin
      wr_pend_q <= take && HWRITE;
      wr_addr_q <= a_addr;
      hrdata_q <= rd_val;
      hready_q <= 1'b1;
      hresp_q <= 1'b0;
    end
  end

  // ============================================================
  // pin synchronisers
  logic rx_m_q, rx_s_q, ck_m_q, ck_s_q, ck_p_q;
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      {rx_m_q, rx_s_q} <= 2'h3;
      {ck_m_q, ck_s_q, ck_p_q} <= 3'h0;
    end else begin
      {rx_m_q, rx_s_q} <= {RX_DT, rx_m_q};
      {ck_m_q, ck_s_q, ck_p_q} <= {CK_IN, ck_m_q, ck_s_q};
    end
  end

  // ============================================================
  // receiver
  usart_rx_pkg::rx_state_t state_q, state_d;
  logic [4:0] timer_q, timer_d;
  logic [3:0] bits_q, bits_d;
  logic [8:0] shift_q, shift_d;
  logic ck_q, ck_d, frame_err_c;

  // single receive only counts in sync master; continuous overrides it
  wire rx_active = port_en && !overrun_q && (cont_en || (sync && master && single_en_q)); // RQ3 RQ4 RQ11
  wire [3:0] nbits = nine_sel ? `NBITS9 : `NBITS8; // RQ2
  wire half_end = (timer_q == 5'(`HALF_CYCLES - 1));
  wire bit_end = (timer_q == 5'(`BIT_CYCLES - 1));
  wire sync_tick = master ? (half_end && !ck_q) : (ck_s_q && !ck_p_q); // RQ9
  wire [4:0] timer_inc = 5'(timer_q + 1'b1);
  wire [8:0] shift_in = {rx_s_q, shift_q[8:1]};
  wire [3:0] bits_inc = 4'(bits_q + 1'b1);
  wire last_bit = (bits_q == 4'(nbits - 1'b1));

  always_comb begin
    state_d = state_q;
    timer_d = timer_q;
    bits_d = bits_q;
    shift_d = shift_q;
    ck_d = ck_q;
    char_done = 1'b0;
    frame_err_c = 1'b0;
    if (!rx_active) begin // RQ1 RQ4
      state_d = usart_rx_pkg::RX_IDLE;
      timer_d = '0;
      bits_d = '0;
      ck_d = 1'b0;
    end else begin
      case (state_q)
        usart_rx_pkg::RX_IDLE: begin
          timer_d = '0;
          bits_d = '0;
          ck_d = 1'b0;
          if (sync) state_d = usart_rx_pkg::RX_DATA; // RQ9
          else if (!rx_s_q) state_d = usart_rx_pkg::RX_START;
        end
        usart_rx_pkg::RX_START: begin
          timer_d = timer_inc;
          if (half_end) begin
            timer_d = '0;
            state_d = rx_s_q ? usart_rx_pkg::RX_IDLE : usart_rx_pkg::RX_DATA;
          end
        end
        usart_rx_pkg::RX_DATA: begin
          if (sync) begin
            if (master) begin
              timer_d = half_end ? 5'h00 : timer_inc;
              if (half_end) ck_d = !ck_q;
            end
            if (sync_tick) begin
              shift_d = shift_in;
              bits_d = bits_inc;
              if (last_bit) begin // RQ2
                char_done = 1'b1;
                state_d = usart_rx_pkg::RX_IDLE;
              end
            end
          end else begin
            timer_d = bit_end ? 5'h00 : timer_inc;
            if (bit_end) begin
              shift_d = shift_in;
              bits_d = bits_inc;
              if (last_bit) state_d = usart_rx_pkg::RX_STOP; // RQ2
            end
          end
        end
        usart_rx_pkg::RX_STOP: begin
          timer_d = timer_inc;
          if (bit_end) begin
            char_done = 1'b1;
            frame_err_c = !rx_s_q; // RQ10
            state_d = usart_rx_pkg::RX_IDLE;
          end
        end
        default: state_d = usart_rx_pkg::RX_IDLE;
      endcase
    end
  end

  wire [7:0] char_data = nine_sel ? shift_d[7:0] : shift_d[8:1];
  wire char_bit8 = nine_sel && shift_d[8]; // RQ8
  wire drop_addr = !sync && nine_sel && addr_det && !char_bit8; // RQ5
  wire accept = char_done && !drop_addr;
  wire ovr_evt = accept && !buf_in_ready; // RQ11
  assign push = accept && buf_in_ready;
  assign buf_in_data = {frame_err_c, char_bit8, char_data};

  always_ff @(posedge CLK) begin
    if (!NRST) begin
      state_q <= usart_rx_pkg::RX_IDLE;
      timer_q <= '0;
      bits_q <= '0;
      shift_q <= '0;
      ck_q <= 1'b0;
    end else begin
      state_q <= state_d;
      timer_q <= timer_d;
      bits_q <= bits_d;
      shift_q <= shift_d;
      ck_q <= ck_d;
    end
  end

  // ============================================================
  // control and status
  wire single_hw_clr = char_done && sync && master; // RQ3
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      rsc_q <= `RSC_RESET;
      mode_q <= `MODE_RESET;
      single_en_q <= 1'b0;
      overrun_q <= 1'b0;
      ninth_last_q <= 1'b0;
      rdy_q <= 1'b0;
    end else begin
      if (wr_rsc) rsc_q <= HWDATA[7:0];
      if (wr_mode) mode_q <= HWDATA[1:0];
      single_en_q <= wr_rsc ? HWDATA[`SINGLE_EN_BIT] : (single_en_q && !single_hw_clr); // RQ3
      overrun_q <= ovr_evt || (overrun_q && cont_en_nx && port_en_nx); // RQ7 RQ11
      if (pop) ninth_last_q <= buf_out_data[`ENT_BIT8]; // RQ8
      rdy_q <= buf_out_valid && !pop;
    end
  end

  // ============================================================
  // outputs
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      CK_OUT <= 1'b0;
      CK_OE <= 1'b0;
      SERIAL_PINS_EN <= 1'b0;
    end else begin
      CK_OUT <= ck_d;
      CK_OE <= port_en_nx && sync && master; // RQ1 RQ9
      SERIAL_PINS_EN <= port_en_nx; // RQ1
    end
  end
  assign HREADYOUT = hready_q;
  assign HRDATA = hrdata_q;
  assign HRESP = hresp_q;
  assign RX_DATA_READY = rdy_q;

  // ============================================================
  // checks
  a_disable_idle: assert property (@(posedge CLK) disable iff (!NRST) // RQ1
    !port_en |=> state_q == usart_rx_pkg::RX_IDLE && !overrun_q) else $error("port off not idle");
  a_bit_count: assert property (@(posedge CLK) disable iff (!NRST) // RQ2
    state_q == usart_rx_pkg::RX_DATA |-> bits_q < nbits) else $error("too many bits");
  a_single_clear: assert property (@(posedge CLK) disable iff (!NRST) // RQ3
    single_hw_clr && !wr_rsc |=> !single_en_q) else $error("single receive not cleared");
  a_off_stays: assert property (@(posedge CLK) disable iff (!NRST) // RQ4
    !rx_active |=> state_q == usart_rx_pkg::RX_IDLE) else $error("receiver ran while off");
  a_addr_filter: assert property (@(posedge CLK) disable iff (!NRST) // RQ5
    char_done && !sync && nine_sel && addr_det && !shift_d[8] |-> !push) else $error("data byte kept");
  a_frame_view: assert property (@(posedge CLK) disable iff (!NRST) // RQ6
    rd_rsc |=> HRDATA[`FRAME_ERR_BIT] == $past(frame_err_view)) else $error("framing view wrong");
  a_overrun_sticky: assert property (@(posedge CLK) disable iff (!NRST) // RQ7
    overrun_q && cont_en && !wr_pend_q |=> overrun_q) else $error("overrun lost");
  a_ovr_set: assert property (@(posedge CLK) disable iff (!NRST) // RQ11
    ovr_evt |=> overrun_q ##1 (state_q == usart_rx_pkg::RX_IDLE)) else $error("overrun not set");
  a_ninth_bit: assert property (@(posedge CLK) disable iff (!NRST) // RQ8
    push && !nine_sel |-> !buf_in_data[`ENT_BIT8]) else $error("ninth bit in 8-bit mode");
  a_stop_low: assert property (@(posedge CLK) disable iff (!NRST) // RQ10
    state_q == usart_rx_pkg::RX_STOP && bit_end && rx_active |-> frame_err_c == !rx_s_q)
    else $error("framing flag mismatch");
endmodule

// ==== dv/serial_far_end.sv ====
// remote serial transmitter that drives the receive line
module serial_far_end (
  input wire logic clk,
  output logic dt,
  output logic ck
);
  timeunit 1ns;
  timeprecision 1ns;
  // line idles at mark level
  initial begin
    dt = 1'b1;
    ck = 1'b0;
  end
  // one character: start bit, data lsb first, then stop bit
  task automatic send(input int nbits, input logic [8:0] d, input logic stop);
    for (int i = 0; i < nbits + 2; i++) begin
      dt <= (i == 0) ? 1'b0 : (i == nbits + 1) ? stop : d[i-1];
      repeat (16) @(posedge clk);
    end
    dt <= 1'b1;
    repeat (16) @(posedge clk);
  endtask
  // synchronous character: data set while clock low, sampled at clock rise
  task automatic send_sync(input int nbits, input logic [8:0] d);
    for (int i = 0; i < nbits; i++) begin
      dt <= d[i];
      repeat (8) @(posedge clk);
      ck <= 1'b1;
      repeat (8) @(posedge clk);
      ck <= 1'b0;
    end
    dt <= 1'b1;
  endtask
endmodule

// ==== dv/test_usart_receive_control.sv ====
// self-checking bench for the serial receive control block
`include "usart_rx_cfg.svh"
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin n_mismatch++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, a, b); end end
module test_usart_receive_control;
  timeunit 1ns;
  timeprecision 100ps;
  // ==========================================================
  // signals
  logic CLK = 1'b0, NRST = 1'b0, HSEL = 1'b0, HWRITE = 1'b0, RX_DT, CK_IN;
  logic [31:0] HADDR = 32'h0, HWDATA = 32'h0, HRDATA, rd;
  logic [1:0] HTRANS = 2'h0;
  logic [2:0] HSIZE = 3'h0;
  logic HREADYOUT, HRESP, CK_OUT, CK_OE, SERIAL_PINS_EN, RX_DATA_READY;
  logic nine = 1'b0;
  logic [9:0] q[$];
  logic [7:0] d;
  int n_mismatch = 0, n_tests = 0, seed = 32'hdaa6;
  usart_receive_control DUT (.CLK(CLK), .NRST(NRST), .HSEL(HSEL), .HADDR(HADDR),
    .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADYOUT),
    .HREADYOUT(HREADYOUT), .HRDATA(HRDATA), .HRESP(HRESP), .RX_DT(RX_DT), .CK_IN(CK_IN),
    .CK_OUT(CK_OUT), .CK_OE(CK_OE), .SERIAL_PINS_EN(SERIAL_PINS_EN),
    .RX_DATA_READY(RX_DATA_READY));
  serial_far_end FAR (.clk(CLK), .dt(RX_DT), .ck(CK_IN));
  initial begin
    forever #12.5 CLK = ~CLK;
  end
  // ==========================================================
  // bus and model tasks
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
    HSEL <= 1'b1;
    HTRANS <= 2'h2;
    HWRITE <= w;
    HSIZE <= 3'h2;
    HADDR <= {24'h0, a};
    do @(posedge CLK); while (HREADYOUT !== 1'b1);
    HSEL <= 1'b0;
    HTRANS <= 2'h0;
    HWDATA <= wd;
    do @(posedge CLK); while (HREADYOUT !== 1'b1);
    rd = HRDATA;
    `CHK(HRESP, 1'b0)
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge CLK);
    #1;
  endtask
  task automatic wait_ready();
    int k;
    k = 0;
    while (RX_DATA_READY !== 1'b1 && k < 400) begin
      settle(1);
      k++;
    end
    `CHK(RX_DATA_READY, 1'b1)
  endtask
  // send one character and record what the receiver should keep
  task automatic tx(input int n, input logic b8, input logic stop, input logic keep);
    d = 8'($random(seed));
    FAR.send(n, {b8, d}, stop);
    if (keep) q.push_back({~stop, b8 & (n == 9), d});
  endtask
  task automatic check_head();
    logic [9:0] h;
    h = q.pop_front();
    bus(1'b0, `RSC_OFF, 32'h0);
    `CHK(rd[`FRAME_ERR_BIT], h[9])
    if (nine) `CHK(rd[`NINTH_BIT], h[8])
    bus(1'b0, `RDR_OFF, 32'h0);
    `CHK(rd[7:0], h[7:0])
  endtask
  task automatic test_done();
    $display("tests %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge CLK);
    n_mismatch++;
    test_done();
  end
  // ==========================================================
  // scenarios
  initial begin
    settle(16);
    NRST <= 1'b1;
    settle(1);
    bus(1'b0, `RSC_OFF, 32'h0);
    `CHK(rd[7:0], `RSC_RESET)
    `CHK(SERIAL_PINS_EN, 1'b0)
    bus(1'b0, 8'h10, 32'h0);
    `CHK(rd, 32'h0)
    bus(1'b1, `RSC_OFF, 32'h90);
    settle(1);
    `CHK(SERIAL_PINS_EN, 1'b1)
    `CHK(CK_OE, 1'b0)
    $display("test reset done");
    for (int i = 0; i < 3; i++) begin
      tx(8, 1'b0, 1'b1, 1'b1);
      wait_ready();
      check_head();
    end
    $display("test async8 done");
    nine = 1'b1;
    bus(1'b1, `RSC_OFF, 32'hd0);
    tx(9, 1'b1, 1'b1, 1'b1);
    tx(9, 1'b0, 1'b1, 1'b1);
    check_head();
    check_head();
    bus(1'b1, `RSC_OFF, 32'hd8);
    tx(9, 1'b0, 1'b1, 1'b0);
    settle(40);
    `CHK(RX_DATA_READY, 1'b0)
    tx(9, 1'b1, 1'b1, 1'b1);
    wait_ready();
    check_head();
    $display("test ninth done");
    nine = 1'b0;
    bus(1'b1, `RSC_OFF, 32'h90);
    tx(8, 1'b0, 1'b0, 1'b1);
    tx(8, 1'b0, 1'b1, 1'b1);
    check_head();
    check_head();
    $display("test framing done");
    for (int i = 0; i < 3; i++) tx(8, 1'b0, 1'b1, i < 2);
    settle(40);
    bus(1'b0, `RSC_OFF, 32'h0);
    `CHK(rd[`OVERRUN_BIT], 1'b1)
    check_head();
    check_head();
    settle(2);
    `CHK(RX_DATA_READY, 1'b0)
    bus(1'b1, `RSC_OFF, 32'h80);
    bus(1'b0, `RSC_OFF, 32'h0);
    `CHK(rd[`OVERRUN_BIT], 1'b0)
    tx(8, 1'b0, 1'b1, 1'b0);
    settle(40);
    `CHK(RX_DATA_READY, 1'b0)
    $display("test overrun done");
    bus(1'b1, `MODE_OFF, 32'h3);
    bus(1'b0, `MODE_OFF, 32'h0);
    `CHK(rd, 32'h3)
    bus(1'b1, `RSC_OFF, 32'ha0);
    settle(1);
    `CHK(CK_OE, 1'b1)
    q.push_back(10'h0ff);
    wait_ready();
    bus(1'b0, `RSC_OFF, 32'h0);
    `CHK(rd[`SINGLE_EN_BIT], 1'b0)
    check_head();
    bus(1'b1, `RSC_OFF, 32'h0);
    settle(1);
    `CHK(SERIAL_PINS_EN, 1'b0)
    `CHK(CK_OE, 1'b0)
    $display("test sync done");
    bus(1'b1, `MODE_OFF, 32'h1);
    bus(1'b1, `RSC_OFF, 32'h90);
    settle(1);
    `CHK(CK_OE, 1'b0)
    d = 8'($random(seed));
    FAR.send_sync(8, {1'b0, d});
    q.push_back({2'b00, d});
    wait_ready();
    check_head();
    bus(1'b1, `RSC_OFF, 32'h0);
    $display("test slave done");
    test_done();
  end
endmodule
